// file: design/mcc_pkg.sv
// Constants and types of the monitor conversion control
package mcc_pkg;
    localparam int          CLK_NS    = 50;
    localparam logic [7:0]  A_VCFG    = 8'h00;
    localparam logic [7:0]  A_TCFG    = 8'h01;
    localparam logic [7:0]  A_STAT    = 8'h02;
    localparam logic [7:0]  A_SHUNT   = 8'h03;
    localparam logic [7:0]  A_BUS     = 8'h04;
    localparam logic [7:0]  A_POWER   = 8'h05;
    localparam logic [7:0]  A_LOCAL   = 8'h06;
    localparam logic [7:0]  A_REMOTE  = 8'h07;
    localparam logic [7:0]  A_MASK    = 8'h08;
    localparam logic [7:0]  A_WDOG    = 8'h09;
    localparam logic [7:0]  GC_ADDR   = 8'h00;
    localparam logic [7:0]  GC_RESET  = 8'h06;
    localparam int          VDONE_BIT = 6;
    localparam int          TDONE_BIT = 5;
    localparam int          SUPPLY_BIT = 1;
    localparam int          OPEN_BIT  = 0;
    localparam logic [2:0]  MODE_PD   = 3'h0;
    localparam logic [2:0]  MODE_OFF  = 3'h4;
    localparam logic [15:0] VCFG_RST  = 16'h0007;
    localparam logic [15:0] TCFG_RST  = 16'hf800;
    localparam logic [15:0] MASK_RST  = 16'hffff;
    localparam logic [15:0] WDOG_RST  = 16'h0000;
    localparam logic [15:0] SHORT_VAL = 16'h8000;
    localparam int RECOVER_NS  = 40_000;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int TEMP_READS  = 4;
    localparam int TEMP_PER_RD = 150;
    localparam int TEMP_SAMPLES = TEMP_READS * TEMP_PER_RD;
    localparam int TEMP_MAX_NS = 130_000_000;
    localparam int TEMP_TICK_CYC = TEMP_MAX_NS / (TEMP_SAMPLES * CLK_NS);
    localparam int VGAP_NS     = 81_000_000;
    localparam int VAVG_MAX    = 128;
    localparam int VOLT_TICK_CYC = VGAP_NS / (VAVG_MAX * CLK_NS);

    typedef struct packed {
        logic       soft_rst;
        logic       single_shot_trigger;
        logic [2:0] rsvd;
        logic [3:0] bus_average_count;
        logic [3:0] shunt_average_count;
        logic [2:0] mode;
    } mcc_vcfg_t;

    typedef struct packed {
        logic        run;
        logic [3:0]  chan_en;
        logic [10:0] rsvd;
    } mcc_tcfg_t;

    typedef enum logic [3:0] {I_IDLE, I_ADDR, I_PTR, I_WHI, I_WLO, I_GC,
                              I_ACK, I_RD, I_MACK} mcc_ist_t;
    typedef enum logic [1:0] {V_IDLE, V_SH, V_BU} mcc_vst_t;
    typedef enum logic       {T_IDLE, T_RUN} mcc_tst_t;
endpackage : mcc_pkg

// file: design/mcc_monitor.sv
// Conversion control of the monitor, with its two-wire register slave
`timescale 1ns/1ps
`default_nettype none
module mcc_monitor #(
    parameter logic [6:0] DEV_ADDR = 7'h4a, // arbitrary value
    parameter int         VTICK    = mcc_pkg::VOLT_TICK_CYC,
    parameter int         TTICK    = mcc_pkg::TEMP_TICK_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [11:0] shunt_adc_i,
    input  wire logic [11:0] bus_adc_i,
    input  wire logic [12:0] local_temp_i,
    input  wire logic [12:0] remote_temp_i,
    input  wire logic        open_diode_i,
    input  wire logic        diode_short_i,
    input  wire logic        supply_ok_i,
    output logic             adc_on_o
);
    import mcc_pkg::*;

    if (VTICK < 1 || TTICK < 1) begin : g_bad
        $error("tick counts must be at least one");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] s1_q, s2_q;
    logic [1:0] s3_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Supply taken as valid until seen, so reset raises no false flag
            s1_q <= 5'h13;
            s2_q <= 5'h13;
            s3_q <= 2'h3;
        end else begin
            s1_q <= {supply_ok_i, diode_short_i, open_diode_i, sda_i, scl_i};
            s2_q <= s1_q;
            s3_q <= s2_q[1:0];
        end
    end
    logic scl, sda, opn, sht, sup, rise, fall, start, stop;
    assign scl   = s2_q[0];
    assign sda   = s2_q[1];
    assign opn   = s2_q[2];
    assign sht   = s2_q[3];
    assign sup   = s2_q[4];
    assign rise  = scl && !s3_q[0];
    assign fall  = !scl && s3_q[0];
    assign start = scl && s3_q[0] && s3_q[1] && !sda;
    assign stop  = scl && s3_q[0] && !s3_q[1] && sda;

    // ------------------------------------------------------------
    // Two-wire slave
    // ------------------------------------------------------------
    mcc_ist_t    ist_q, nxt_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q, tx_q, ptr_q, whi_q, nb;
    logic [15:0] wd_q, rw_q, rdat;
    logic        oe_q, nack_q, bsel_q, wr_q, gcr_q, strd_q, ld, rx;
    assign rx = ist_q inside {I_ADDR, I_PTR, I_WHI, I_WLO, I_GC};
    assign ld = fall && ((ist_q == I_ACK && nxt_q == I_RD) ||
                         (ist_q == I_MACK && !nack_q));
    assign nb = bsel_q ? rw_q[7:0] : rdat[15:8];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ist_q  <= I_IDLE;
            nxt_q  <= I_IDLE;
            cnt_q  <= 4'h0;
            sh_q   <= 8'h00;
            tx_q   <= 8'h00;
            ptr_q  <= 8'h00;
            whi_q  <= 8'h00;
            wd_q   <= 16'h0000;
            rw_q   <= 16'h0000;
            oe_q   <= 1'b0;
            nack_q <= 1'b0;
            bsel_q <= 1'b0;
            wr_q   <= 1'b0;
            gcr_q  <= 1'b0;
            strd_q <= 1'b0;
        end else begin
            wr_q   <= 1'b0;
            gcr_q  <= 1'b0;
            strd_q <= 1'b0;
            if (start) begin
                ist_q <= I_ADDR;
                cnt_q <= 4'h0;
                oe_q  <= 1'b0;
            end else if (stop) begin
                ist_q <= I_IDLE;
                oe_q  <= 1'b0;
            end else if (rise && rx) begin
                sh_q  <= {sh_q[6:0], sda};
                cnt_q <= cnt_q + 4'h1;
            end else if (rise && ist_q == I_MACK) begin
                nack_q <= sda;
            end else if (fall) begin
                case (ist_q)
                    I_ADDR: if (cnt_q == 4'h8) begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                            oe_q   <= 1'b1;
                            ist_q  <= I_ACK;
                            nxt_q  <= sh_q[0] ? I_RD : I_PTR;
                            bsel_q <= 1'b0;
                        end else if (sh_q == GC_ADDR) begin
                            oe_q  <= 1'b1;
                            ist_q <= I_ACK;
                            nxt_q <= I_GC;
                        end else begin
                            ist_q <= I_IDLE;
                        end
                    end
                    I_PTR: if (cnt_q == 4'h8) begin
                        ptr_q <= sh_q;
                        oe_q  <= 1'b1;
                        ist_q <= I_ACK;
                        nxt_q <= I_WHI;
                    end
                    I_WHI: if (cnt_q == 4'h8) begin
                        whi_q <= sh_q;
                        oe_q  <= 1'b1;
                        ist_q <= I_ACK;
                        nxt_q <= I_WLO;
                    end
                    I_WLO: if (cnt_q == 4'h8) begin
                        wd_q  <= {whi_q, sh_q};
                        wr_q  <= 1'b1;
                        oe_q  <= 1'b1;
                        ist_q <= I_ACK;
                        nxt_q <= I_WHI;
                    end
                    I_GC: if (cnt_q == 4'h8) begin
                        gcr_q <= (sh_q == GC_RESET);
                        oe_q  <= 1'b1;
                        ist_q <= I_ACK;
                        nxt_q <= I_IDLE;
                    end
                    I_ACK: begin
                        cnt_q <= 4'h0;
                        ist_q <= nxt_q;
                        oe_q  <= 1'b0;
                    end
                    I_RD: if (cnt_q == 4'h8) begin
                        oe_q  <= 1'b0;
                        ist_q <= I_MACK;
                    end else begin
                        oe_q  <= !tx_q[7];
                        tx_q  <= {tx_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    I_MACK: ist_q <= nack_q ? I_IDLE : I_RD;
                    default: ist_q <= I_IDLE;
                endcase
                // Low byte comes from the word latched with the high byte
                if (ld) begin
                    oe_q   <= !nb[7];
                    tx_q   <= {nb[6:0], 1'b0};
                    cnt_q  <= 4'h1;
                    bsel_q <= !bsel_q;
                    if (!bsel_q) begin
                        rw_q   <= rdat;
                        strd_q <= (ptr_q == A_STAT);
                    end
                end
            end
        end
    end
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    mcc_vcfg_t   vcfg_q;
    mcc_tcfg_t   tcfg_q;
    logic [15:0] mask_q, wdog_q, pwr_q, local_q, remote_q;
    logic [11:0] shunt_q, bus_q;
    logic        vdone_q, tdone_q, srst, shot, v_fin, t_fin;
    assign srst = gcr_q || (wr_q && ptr_q == A_VCFG && wd_q[15]);
    assign shot = wr_q && ptr_q == A_VCFG && wd_q[14] && !wd_q[15];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vcfg_q <= VCFG_RST;
            tcfg_q <= TCFG_RST;
            mask_q <= MASK_RST;
            wdog_q <= WDOG_RST;
        end else if (srst) begin
            vcfg_q <= VCFG_RST;
            tcfg_q <= TCFG_RST;
            mask_q <= MASK_RST;
            wdog_q <= WDOG_RST;
        end else if (wr_q) begin
            case (ptr_q)
                A_VCFG:  vcfg_q <= {2'b00, wd_q[13:0]};
                A_TCFG:  tcfg_q <= wd_q;
                A_MASK:  mask_q <= wd_q;
                A_WDOG:  wdog_q <= wd_q;
                default: ;
            endcase
        end
    end

    // Setting wins over clearing so a conversion finishing in the clearing cycle is not lost
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vdone_q <= 1'b0;
            tdone_q <= 1'b0;
        end else begin
            vdone_q <= v_fin
                       || (vdone_q && !(strd_q || shot || srst));
            tdone_q <= t_fin
                       || (tdone_q && !(strd_q || shot || srst));
        end
    end

    always_comb begin
        rdat = 16'h0000;
        case (ptr_q)
            A_VCFG:   rdat = vcfg_q;
            A_TCFG:   rdat = tcfg_q;
            A_STAT:   begin
                rdat[VDONE_BIT] = vdone_q;
                rdat[TDONE_BIT] = tdone_q;
            end
            A_SHUNT:  rdat = {4'h0, shunt_q};
            A_BUS:    rdat = {4'h0, bus_q};
            A_POWER:  rdat = pwr_q;
            A_LOCAL:  rdat = local_q;
            A_REMOTE: rdat = remote_q;
            A_MASK:   rdat = mask_q;
            A_WDOG:   rdat = wdog_q;
            default:  rdat = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Voltage conversion
    // ------------------------------------------------------------
    function automatic logic [11:0] avg_out(input logic [18:0] s,
                                            input logic [2:0]  n);
        avg_out = 12'(s >> n);
    endfunction : avg_out

    mcc_vst_t    vst_q;
    logic [31:0] vtc_q;
    logic [6:0]  vsc_q;
    logic [18:0] acc_q, vsum;
    logic [2:0]  vn;
    logic [9:0]  rec_q;
    logic        sh_en, bu_en, cont, v_go, v_kill, vtick, shot_pend_q;
    assign sh_en  = vcfg_q.mode[0];
    assign bu_en  = vcfg_q.mode[1];
    assign cont   = vcfg_q.mode[2];
    assign v_kill = srst || vcfg_q.mode == MODE_PD;
    // A continuous mode with no channel is ADC off: nothing restarts
    assign v_go   = vst_q == V_IDLE && rec_q == 10'h000
                    && (sh_en || bu_en)
                    && (cont || shot || shot_pend_q);
    assign vn     = (vst_q == V_SH) ? vcfg_q.shunt_average_count[2:0]
                                    : vcfg_q.bus_average_count[2:0];
    assign vsum   = acc_q + 19'(vst_q == V_SH ? shunt_adc_i : bus_adc_i);
    assign vtick  = vtc_q == 32'(VTICK - 1);
    assign adc_on_o = vcfg_q.mode != MODE_PD;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rec_q <= 10'h000;
        end else if (vcfg_q.mode == MODE_PD) begin
            rec_q <= 10'(RECOVER_CYC);
        end else if (rec_q != 10'h000) begin
            rec_q <= rec_q - 10'h001;
        end
    end

    // A trigger written while leaving power-down waits out the recovery
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shot_pend_q <= 1'b0;
        end else if (shot && rec_q != 10'h000) begin
            shot_pend_q <= 1'b1;
        end else if (v_kill || rec_q == 10'h000) begin
            shot_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vst_q   <= V_IDLE;
            vtc_q   <= 32'h0;
            vsc_q   <= 7'h00;
            acc_q   <= 19'h0;
            shunt_q <= 12'h000;
            bus_q   <= 12'h000;
            v_fin   <= 1'b0;
        end else begin
            v_fin <= 1'b0;
            if (v_kill) begin
                vst_q <= V_IDLE;
            end else if (vst_q == V_IDLE) begin
                if (v_go) begin
                    vst_q <= sh_en ? V_SH : V_BU;
                    vtc_q <= 32'h0;
                    vsc_q <= 7'h00;
                    acc_q <= 19'h0;
                end
            end else if (!vtick) begin
                vtc_q <= vtc_q + 32'h1;
            end else begin
                vtc_q <= 32'h0;
                vsc_q <= vsc_q + 7'h01;
                acc_q <= vsum;
                if (vsc_q == 7'((8'h01 << vn) - 8'h01)) begin
                    vsc_q <= 7'h00;
                    acc_q <= 19'h0;
                    if (vst_q == V_SH) begin
                        shunt_q <= avg_out(vsum, vn);
                    end else begin
                        bus_q <= avg_out(vsum, vn);
                    end
                    // Bus follows shunt, so the two are sampled apart
                    if (vst_q == V_SH && bu_en) begin
                        vst_q <= V_BU;
                    end else begin
                        vst_q <= V_IDLE;
                        v_fin <= 1'b1;
                    end
                end
            end
        end
    end

    // Product runs beside the converter and never delays it
    logic [23:0] prod;
    assign prod = shunt_q * bus_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_q <= 16'h0000;
        end else begin
            pwr_q <= prod[23:8];
        end
    end

    // ------------------------------------------------------------
    // Temperature conversion
    // ------------------------------------------------------------
    mcc_tst_t    tst_q;
    logic [31:0] ttc_q;
    logic [9:0]  tsc_q;
    logic        open_q, bad_q, t_go, t_halt, t_end;
    assign t_halt = srst || tcfg_q[15:11] == 5'h00;
    assign t_go   = tst_q == T_IDLE && tcfg_q.chan_en != 4'h0
                    && (tcfg_q.run || shot);
    assign t_end  = tst_q == T_RUN && ttc_q == 32'(TTICK - 1)
                    && tsc_q == 10'(TEMP_SAMPLES - 1);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tst_q    <= T_IDLE;
            ttc_q    <= 32'h0;
            tsc_q    <= 10'h000;
            open_q   <= 1'b0;
            bad_q    <= 1'b0;
            local_q  <= 16'h0000;
            remote_q <= 16'h0000;
            t_fin    <= 1'b0;
        end else begin
            t_fin <= 1'b0;
            if (t_halt) begin
                tst_q <= T_IDLE;
            end else if (tst_q == T_IDLE) begin
                if (t_go && !sup) begin
                    local_q[SUPPLY_BIT]  <= 1'b1;
                    remote_q[SUPPLY_BIT] <= 1'b1;
                end else if (t_go) begin
                    tst_q  <= T_RUN;
                    ttc_q  <= 32'h0;
                    tsc_q  <= 10'h000;
                    open_q <= 1'b0;
                    bad_q  <= 1'b0;
                end
            end else if (t_end) begin
                tst_q    <= T_IDLE;
                t_fin    <= 1'b1;
                local_q  <= {local_temp_i, 1'b0, bad_q || !sup, 1'b0};
                remote_q <= sht ? SHORT_VAL
                          : {remote_temp_i, 1'b0, bad_q || !sup,
                             open_q || opn};
            end else begin
                open_q <= open_q || opn;
                bad_q  <= bad_q || !sup;
                if (ttc_q == 32'(TTICK - 1)) begin
                    ttc_q <= 32'h0;
                    tsc_q <= tsc_q + 10'h001;
                end else begin
                    ttc_q <= ttc_q + 32'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_shot_go;
        (shot || shot_pend_q) && vst_q == V_IDLE && !cont
            && (sh_en || bu_en) && rec_q == 10'h000
            && vcfg_q.mode != MODE_PD;
    endsequence
    property p_shot_start;
        s_shot_go |=> vst_q != V_IDLE;
    endproperty
    a_shot_start: assert property (p_shot_start)
        else $error("single shot did not start a conversion");
    property p_shot_clr;
        shot && !v_fin && !t_fin |=> !vdone_q && !tdone_q;
    endproperty
    a_shot_clr: assert property (p_shot_clr)
        else $error("single shot did not clear ready flags");
    property p_pd_stop;
        vcfg_q.mode == MODE_PD |=> vst_q == V_IDLE;
    endproperty
    a_pd_stop: assert property (p_pd_stop)
        else $error("voltage conversion runs in power-down");
    property p_thalt;
        tcfg_q[15:11] == 5'h00 |=> tst_q == T_IDLE;
    endproperty
    a_thalt: assert property (p_thalt)
        else $error("temperature runs after immediate halt");
    property p_vdone;
        v_fin |=> vdone_q;
    endproperty
    a_vdone: assert property (p_vdone)
        else $error("voltage done flag not set");
    property p_rdclr;
        strd_q && !v_fin && !t_fin |=> !vdone_q && !tdone_q;
    endproperty
    a_rdclr: assert property (p_rdclr)
        else $error("status read did not clear ready flags");
    property p_short;
        t_end && !t_halt && sht |=> remote_q == SHORT_VAL;
    endproperty
    a_short: assert property (p_short)
        else $error("short did not report -256");
    property p_open;
        t_end && !t_halt && !sht && opn |=> remote_q[OPEN_BIT];
    endproperty
    a_open: assert property (p_open)
        else $error("open diode not reported");
    property p_recover;
        $fell(vcfg_q.mode == MODE_PD)
            |-> rec_q == 10'(RECOVER_CYC) ##0 (vst_q == V_IDLE) [*8];
    endproperty
    a_recover: assert property (p_recover)
        else $error("conversion started during recovery");
    property p_keep;
        vst_q != V_IDLE && v_kill |=> shunt_q == $past(shunt_q)
                                      && bus_q == $past(bus_q);
    endproperty
    a_keep: assert property (p_keep)
        else $error("abort changed a result");
    property p_gc;
        gcr_q |=> vcfg_q == VCFG_RST && mask_q == MASK_RST;
    endproperty
    a_gc: assert property (p_gc)
        else $error("general call reset did not restore registers");
endmodule : mcc_monitor
`default_nettype wire

// file: sim/mcc_host.sv
// Two-wire bus host model driving the monitor register port
`timescale 1ns/1ps
`default_nettype none
module mcc_host (
    output logic      scl_o,
    output logic      oe_o,
    input  wire logic sda_i
);
    // ------------------------------------------------------------
    // Bit engine: 400 ns per bit, clock stands high between frames
    // ------------------------------------------------------------
    initial begin
        scl_o = 1'b1;
        oe_o  = 1'b0;
    end
    task automatic start();
        oe_o = 1'b0;
        #100 scl_o = 1'b1;
        #200 oe_o = 1'b1;
        #200 scl_o = 1'b0;
        #100;
    endtask : start
    task automatic stop();
        oe_o = 1'b1;
        #100 scl_o = 1'b1;
        #200 oe_o = 1'b0;
        #200;
    endtask : stop
    // Data changes only while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        oe_o = !b;
        #100 scl_o = 1'b1;
        #100 s = sda_i;
        #100 scl_o = 1'b0;
        #100;
    endtask : clk_bit
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(last, s);
    endtask : rbyte
endmodule : mcc_host
`default_nettype wire

// file: sim/test_mcc_monitor.sv
// Self-checking bench of the monitor conversion control
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, g, e); \
    end end
module test_mcc_monitor;
    import mcc_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        scl, h_oe, d_oe, d_o, sda, ack, adc_on;
    logic        opn = 1'b0, sht = 1'b0, sok = 1'b1;
    logic [11:0] sh, bv, sv;
    logic [12:0] lt, rt;
    logic [15:0] v, mdl [2];
    int          error_cnt = 0, samples_checked = 0, seed = 76;
    always #25 mclk_i = ~mclk_i;
    // Open-drain data line with pull-up
    assign sda = (d_oe ? d_o : 1'b1) && !h_oe;
    mcc_host h (.scl_o(scl), .oe_o(h_oe), .sda_i(sda));
    mcc_monitor #(.VTICK(2), .TTICK(2)) uut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
        .sda_o(d_o), .sda_oe_o(d_oe), .shunt_adc_i(sh), .bus_adc_i(bv),
        .local_temp_i(lt), .remote_temp_i(rt), .open_diode_i(opn),
        .diode_short_i(sht), .supply_ok_i(sok), .adc_on_o(adc_on));
    // ------------------------------------------------------------
    // Bus tasks and register model
    // ------------------------------------------------------------
    task automatic go(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : go
    task automatic hdr(input logic [7:0] p);
        go(1);
        h.start();
        h.wbyte(8'h94, ack);
        h.wbyte(p, ack);
    endtask : hdr
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        hdr(p);
        h.wbyte(d[15:8], ack);
        h.wbyte(d[7:0], ack);
        h.stop();
        // Single-shot bit reads back as zero
        if (p < 8'h02) mdl[p[0]] = d & 16'hbfff;
    endtask : wr
    task automatic chk(input logic [7:0] p, input logic [15:0] e, m);
        hdr(p);
        h.start();
        h.wbyte(8'h95, ack);
        h.rbyte(1'b0, v[15:8]);
        h.rbyte(1'b1, v[7:0]);
        h.stop();
        `CHK(v & m, e & m)
    endtask : chk
    task automatic gc(input logic [7:0] b);
        go(1);
        h.start();
        h.wbyte(GC_ADDR, ack);
        `CHK(ack, 1'b1)
        h.wbyte(b, ack);
        h.stop();
        if (b == GC_RESET) begin
            mdl[0] = VCFG_RST;
            mdl[1] = TCFG_RST;
        end
    endtask : gc
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #4_000_000;
        error_cnt++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        mdl[0] = VCFG_RST;
        mdl[1] = TCFG_RST;
        sh = 12'($random(seed));
        bv = 12'($random(seed));
        lt = 13'($random(seed));
        rt = 13'($random(seed));
        repeat (20) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        go(4);
        chk(A_VCFG, mdl[0], 16'hffff);
        chk(A_TCFG, mdl[1], 16'hffff);
        chk(8'h0c, 16'h0000, 16'hffff);
        `CHK(adc_on, 1'b1)
        chk(A_SHUNT, {4'h0, sh}, 16'hffff);
        chk(A_BUS, {4'h0, bv}, 16'hffff);
        chk(A_POWER, 16'((24'(sh) * 24'(bv)) >> 8), 16'hffff);
        chk(A_LOCAL, {lt, 3'h0}, 16'hfffb);
        chk(A_REMOTE, {rt, 3'h0}, 16'hfffb);
        $display("test power-up done");
        opn = 1'b1;
        go(3000);
        chk(A_REMOTE, 16'h0001, 16'h0001);
        opn = 1'b0;
        sht = 1'b1;
        go(3000);
        chk(A_REMOTE, SHORT_VAL, 16'hffff);
        sht = 1'b0;
        sok = 1'b0;
        go(3000);
        chk(A_LOCAL, 16'h0002, 16'h0002);
        sok = 1'b1;
        $display("test faults done");
        wr(A_VCFG, 16'h0000);
        `CHK(adc_on, 1'b0)
        wr(A_TCFG, 16'h0000);
        sh = 12'($random(seed));
        wr(A_VCFG, 16'h4003);
        go(2000);
        chk(A_STAT, 16'h0040, 16'h0040);
        chk(A_STAT, 16'h0000, 16'h0040);
        chk(A_SHUNT, {4'h0, sh}, 16'hffff);
        chk(A_VCFG, mdl[0], 16'hffff);
        wr(A_VCFG, 16'h0004);
        sv = sh;
        sh = ~sh;
        go(2000);
        chk(A_SHUNT, {4'h0, sv}, 16'hffff);
        $display("test one-shot done");
        gc(8'h55);
        chk(A_VCFG, mdl[0], 16'hffff);
        gc(GC_RESET);
        chk(A_VCFG, mdl[0], 16'hffff);
        chk(A_TCFG, mdl[1], 16'hffff);
        $display("test general call done");
        give_verdict();
    end
endmodule : test_mcc_monitor
`default_nettype wire
